// [logic/fcs_params.svh]
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH

// ----------------------------------------
// command codes (low byte of the 16-bit write)
// ----------------------------------------
`define FCS_CODE_READ_ARRAY 8'hFF
`define FCS_CODE_READ_STATUS 8'h70
`define FCS_CODE_CLEAR_STATUS 8'h50
`define FCS_CODE_PROGRAM 8'h41
`define FCS_CODE_ERASE 8'h20
`define FCS_CODE_LOCK_PROGRAM 8'h77
`define FCS_CODE_LOCK_READ 8'h71
`define FCS_CODE_BLANK_CHECK 8'h25
`define FCS_CODE_CONFIRM 8'hD0
`define FCS_CODE_HIGH_BYTE 8'h00

// ----------------------------------------
// status value bit positions
// ----------------------------------------
`define FCS_SR_READY_BIT 7
`define FCS_SR_ERASE_BIT 5
`define FCS_SR_PROGRAM_BIT 4

// ----------------------------------------
// counts
// ----------------------------------------
`define FCS_ERASE_RETRIES 3
`define FCS_HIGH_WORD_OFFSET 2
`define FCS_POLL_LIMIT 65536

`endif

// [logic/fcs_pkg.sv]
package fcs_pkg;

  // operations the user side can order
  typedef enum logic [2:0] {
    FCS_OP_READ_ARRAY,
    FCS_OP_READ_STATUS,
    FCS_OP_CLEAR_STATUS,
    FCS_OP_PROGRAM,
    FCS_OP_ERASE,
    FCS_OP_LOCK_PROGRAM,
    FCS_OP_LOCK_READ,
    FCS_OP_BLANK_CHECK
  } fcs_op_t;

  // sequencer states
  typedef enum logic [2:0] {
    FCS_ST_IDLE,
    FCS_ST_BUS,
    FCS_ST_WAIT,
    FCS_ST_POLL,
    FCS_ST_RETRY,
    FCS_ST_RETRY_WAIT,
    FCS_ST_DONE
  } fcs_state_t;

endpackage

// [logic/fcs_bus_cycle.sv]
`timescale 1ns/100ps
`include "fcs_params.svh"

module fcs_bus_cycle #(
  parameter int AW = 20
) (
  input logic clock,
  input logic rst,
  input logic start,
  input logic isWrite,
  input logic [AW-1:0] addr,
  input logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  output logic [AW-1:0] memAddr,
  output logic [15:0] memWdata,
  output logic memWe,
  output logic memRe,
  input logic [15:0] memRdata,
  input logic memAck
);

  logic busy;
  assign busy = memWe | memRe;

  // ----------------------------------------
  // one 16-bit cycle: strobe held until the device acknowledges
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      memAddr <= '0;
      memWdata <= 16'h0000;
      memWe <= 1'b0;
      memRe <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        memAddr <= {addr[AW-1:1], 1'b0};
        memWdata <= wdata;
        memWe <= isWrite;
        memRe <= !isWrite;
      end else if (busy && memAck) begin
        memWe <= 1'b0;
        memRe <= 1'b0;
        done <= 1'b1;
        rdata <= memRdata;
      end
    end
  end

  AST_EVEN_ADDRESS: assert property (@(posedge clock) disable iff (rst)
    busy |-> memAddr[0] == 1'b0)
    else $error("flash cycle on an odd address");

endmodule

// [logic/fcs_host.sv]
// Notes on behaviour
// - commands and data go as 16-bit words to even addresses; high byte ignored.
// - never issue status read while in-place rewrite mode is selected.
// - program writes 41, low word, high word; then automatic program starts.
// - never program a location already written before its block is erased; code only refuses a repeat of the last programmed address.
// - erase writes 20 then D0 to the block's highest even address.
// - after an erase error clear status and retry erase up to three times.
// - lock program writes 77 then D0 to the same block address.
// - lock read writes 71 then D0; read lock result after ready returns.
// - blank check writes 25 then D0; not-blank shows in erase-error flag.
// - enable bits are set by writing 0 then 1 with nothing between.
// - no program, erase or lock or blank commands while main clock stopped.
// - CPU clock at most 10 MHz and wait state set before rewrite mode; code only refuses orders while either is missing.
`timescale 1ns/100ps
`include "fcs_params.svh"

module fcs_host
  import fcs_pkg::*;
#(
  parameter int AW = 20,
  parameter int POLL_LIMIT = `FCS_POLL_LIMIT
) (
  input logic clock,
  input logic rst,
  input logic cmdValid,
  input fcs_op_t cmdOp,
  input logic [AW-1:0] cmdAddr,
  input logic [15:0] cmdDataLo,
  input logic [15:0] cmdDataHi,
  output logic cmdReady,
  output logic rspValid,
  output logic rspRefused,
  output logic rspTimeout,
  output logic [7:0] rspStatus,
  output logic [15:0] rspData,
  output logic rspLock,
  input logic rewriteRequest,
  input logic lockDisableRequest,
  input logic inPlaceRequest,
  input logic mainClockStop,
  input logic cpuClockSlow,
  input logic waitStateSet,
  input logic flashRegsReset,
  output logic [AW-1:0] memAddr,
  output logic [15:0] memWdata,
  output logic memWe,
  output logic memRe,
  input logic [15:0] memRdata,
  input logic memAck,
  output logic rewriteModeEnable,
  output logic lockFunctionDisable,
  output logic inPlaceRewriteMode,
  input logic sequencerReadyFlag,
  input logic programErrorFlag,
  input logic eraseErrorFlag,
  input logic lockStateResult
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  fcs_state_t state_reg, state_next;
  fcs_op_t op_reg;
  logic [AW-1:0] addr_reg;
  logic [15:0] lo_reg, hi_reg;
  logic [1:0] step_reg;
  logic [1:0] retry_reg;
  logic [$clog2(POLL_LIMIT+1)-1:0] poll_reg;
  logic timeout_reg;
  logic [AW-1:0] lastProg_reg;
  logic lastProgValid_reg;
  logic [1:0] enArmed_reg;
  logic [1:0] enOut_reg;
  logic busDone;
  logic [15:0] busRdata;

  // ----------------------------------------
  // enable bits: 0 first, 1 on the very next edge
  // ----------------------------------------
  logic [1:0] enWant;
  assign enWant = {lockDisableRequest, rewriteRequest};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_enable
      // arming cycle writes 0; the set follows with no gap for anything else
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          enArmed_reg[gi] <= 1'b0;
          enOut_reg[gi] <= 1'b0;
        end else if (flashRegsReset || !enWant[gi]) begin
          enArmed_reg[gi] <= 1'b0;
          enOut_reg[gi] <= 1'b0;
        end else begin
          enArmed_reg[gi] <= !enOut_reg[gi] && !enArmed_reg[gi];
          enOut_reg[gi] <= enOut_reg[gi] | enArmed_reg[gi];
        end
      end
    end
  endgenerate

  assign rewriteModeEnable = enOut_reg[0];
  assign lockFunctionDisable = enOut_reg[1];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inPlaceRewriteMode <= 1'b0;
    end else if (state_reg == FCS_ST_IDLE && !accept) begin
      // frozen on the taking edge so the admission check and the order agree
      inPlaceRewriteMode <= inPlaceRequest;
    end
  end

  // ----------------------------------------
  // admission checks on a new order
  // ----------------------------------------
  logic heavyOp, clockOk, refuse, accept;
  assign heavyOp = cmdOp inside {FCS_OP_PROGRAM, FCS_OP_ERASE, FCS_OP_LOCK_PROGRAM,
                                 FCS_OP_LOCK_READ, FCS_OP_BLANK_CHECK};
  assign clockOk = cpuClockSlow && waitStateSet;
  assign refuse = !rewriteModeEnable || !clockOk
                  || (heavyOp && mainClockStop)
                  || (cmdOp == FCS_OP_READ_STATUS && inPlaceRewriteMode)
                  || (cmdOp == FCS_OP_PROGRAM && lastProgValid_reg
                      && lastProg_reg == cmdAddr);
  assign accept = state_reg == FCS_ST_IDLE && cmdValid && cmdReady;

  // ----------------------------------------
  // bus cycle table per operation and step
  // ----------------------------------------
  function automatic logic [7:0] fcs_first_code(input fcs_op_t op);
    case (op)
      FCS_OP_READ_ARRAY: fcs_first_code = `FCS_CODE_READ_ARRAY;
      FCS_OP_READ_STATUS: fcs_first_code = `FCS_CODE_READ_STATUS;
      FCS_OP_CLEAR_STATUS: fcs_first_code = `FCS_CODE_CLEAR_STATUS;
      FCS_OP_PROGRAM: fcs_first_code = `FCS_CODE_PROGRAM;
      FCS_OP_ERASE: fcs_first_code = `FCS_CODE_ERASE;
      FCS_OP_LOCK_PROGRAM: fcs_first_code = `FCS_CODE_LOCK_PROGRAM;
      FCS_OP_LOCK_READ: fcs_first_code = `FCS_CODE_LOCK_READ;
      default: fcs_first_code = `FCS_CODE_BLANK_CHECK;
    endcase
  endfunction

  logic isRead2, needsPoll, stepLast, stepWrite, inRetry;
  logic [AW-1:0] stepAddr;
  logic [15:0] stepData, busData;
  assign isRead2 = op_reg inside {FCS_OP_READ_ARRAY, FCS_OP_READ_STATUS};
  assign needsPoll = !isRead2 && op_reg != FCS_OP_CLEAR_STATUS;
  assign stepWrite = !(isRead2 && step_reg == 2'd1);
  assign stepLast = op_reg == FCS_OP_CLEAR_STATUS
                    || (op_reg == FCS_OP_PROGRAM ? step_reg == 2'd2 : step_reg == 2'd1);
  // high word goes to the next word address; block ops reuse the block address
  assign stepAddr = (op_reg == FCS_OP_PROGRAM && step_reg == 2'd2)
                    ? addr_reg + AW'(`FCS_HIGH_WORD_OFFSET) : addr_reg;
  assign stepData = step_reg == 2'd0 ? {`FCS_CODE_HIGH_BYTE, fcs_first_code(op_reg)}
                  : op_reg == FCS_OP_PROGRAM ? (step_reg == 2'd1 ? lo_reg : hi_reg)
                  : {`FCS_CODE_HIGH_BYTE, `FCS_CODE_CONFIRM};
  assign inRetry = state_reg == FCS_ST_RETRY;
  assign busData = inRetry ? {`FCS_CODE_HIGH_BYTE, `FCS_CODE_CLEAR_STATUS} : stepData;

  fcs_bus_cycle #(
    .AW(AW)
  ) u_bus (
    .clock(clock),
    .rst(rst),
    .start(state_reg == FCS_ST_BUS || inRetry),
    .isWrite(inRetry || stepWrite),
    .addr(stepAddr),
    .wdata(busData),
    .done(busDone),
    .rdata(busRdata),
    .memAddr(memAddr),
    .memWdata(memWdata),
    .memWe(memWe),
    .memRe(memRe),
    .memRdata(memRdata),
    .memAck(memAck)
  );

  // ----------------------------------------
  // sequencer next state
  // ----------------------------------------
  logic pollSeen, pollExpired, retryErase;
  // first poll cycle is skipped so the ready flag has time to drop
  assign pollSeen = poll_reg != '0 && sequencerReadyFlag;
  assign pollExpired = poll_reg == ($bits(poll_reg))'(POLL_LIMIT);
  assign retryErase = op_reg == FCS_OP_ERASE && eraseErrorFlag
                      && retry_reg < 2'(`FCS_ERASE_RETRIES);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FCS_ST_IDLE: if (accept) state_next = refuse ? FCS_ST_DONE : FCS_ST_BUS;
      FCS_ST_BUS: state_next = FCS_ST_WAIT;
      FCS_ST_WAIT: begin
        if (busDone) begin
          state_next = !stepLast ? FCS_ST_BUS : needsPoll ? FCS_ST_POLL : FCS_ST_DONE;
        end
      end
      FCS_ST_POLL: begin
        if (flashRegsReset || pollExpired) state_next = FCS_ST_DONE;
        else if (pollSeen) state_next = retryErase ? FCS_ST_RETRY : FCS_ST_DONE;
      end
      FCS_ST_RETRY: state_next = FCS_ST_RETRY_WAIT;
      FCS_ST_RETRY_WAIT: if (busDone) state_next = FCS_ST_BUS;
      FCS_ST_DONE: state_next = FCS_ST_IDLE;
      default: state_next = FCS_ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // sequencer registers
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= FCS_ST_IDLE;
      op_reg <= FCS_OP_READ_ARRAY;
      addr_reg <= '0;
      lo_reg <= 16'h0000;
      hi_reg <= 16'h0000;
      step_reg <= 2'd0;
      retry_reg <= 2'd0;
      poll_reg <= '0;
      timeout_reg <= 1'b0;
      rspRefused <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        op_reg <= cmdOp;
        addr_reg <= cmdAddr;
        lo_reg <= cmdDataLo;
        hi_reg <= cmdDataHi;
        step_reg <= 2'd0;
        retry_reg <= 2'd0;
        timeout_reg <= 1'b0;
        rspRefused <= refuse;
      end
      if (state_reg == FCS_ST_WAIT && busDone && !stepLast) step_reg <= step_reg + 2'd1;
      if (state_reg == FCS_ST_RETRY) begin
        step_reg <= 2'd0;
        retry_reg <= retry_reg + 2'd1;
      end
      poll_reg <= state_reg == FCS_ST_POLL ? poll_reg + 1'b1 : '0;
      if (state_reg == FCS_ST_POLL && (pollExpired || flashRegsReset)) timeout_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // answer to the user and program bookkeeping
  // ----------------------------------------
  logic [7:0] statusNow;
  always_comb begin
    statusNow = 8'h00;
    statusNow[`FCS_SR_READY_BIT] = sequencerReadyFlag;
    statusNow[`FCS_SR_ERASE_BIT] = eraseErrorFlag;
    statusNow[`FCS_SR_PROGRAM_BIT] = programErrorFlag;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmdReady <= 1'b1;
      rspValid <= 1'b0;
      rspTimeout <= 1'b0;
      rspStatus <= 8'h80;
      rspData <= 16'h0000;
      rspLock <= 1'b0;
      lastProg_reg <= '0;
      lastProgValid_reg <= 1'b0;
    end else begin
      rspValid <= state_reg == FCS_ST_DONE;
      cmdReady <= state_next == FCS_ST_IDLE && state_reg != FCS_ST_DONE;
      if (state_reg == FCS_ST_DONE) begin
        rspTimeout <= timeout_reg;
        rspStatus <= statusNow;
        rspLock <= lockStateResult;
      end
      if (state_reg == FCS_ST_WAIT && busDone && isRead2) rspData <= busRdata;
      // remember the last programmed word; an erase without erase error clears the record
      if (state_reg == FCS_ST_DONE && !rspRefused) begin
        if (op_reg == FCS_OP_PROGRAM) begin
          lastProg_reg <= addr_reg;
          lastProgValid_reg <= 1'b1;
        end else if (op_reg == FCS_OP_ERASE && !eraseErrorFlag) begin
          lastProgValid_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_NO_STATUS_IN_PLACE: assert property (@(posedge clock) disable iff (rst)
    state_reg == FCS_ST_BUS && op_reg == FCS_OP_READ_STATUS |-> !inPlaceRewriteMode)
    else $error("status read issued in in-place rewrite mode");

  AST_ENABLE_ZERO_FIRST: assert property (@(posedge clock) disable iff (rst)
    $rose(rewriteModeEnable) |-> $past(enArmed_reg[0]) && !$past(rewriteModeEnable, 2))
    else $error("rewrite enable set without a preceding zero write");

  AST_CLOCK_STOP_REFUSED: assert property (@(posedge clock) disable iff (rst)
    accept && heavyOp && mainClockStop |=> state_reg == FCS_ST_DONE ##1 rspValid && rspRefused)
    else $error("heavy command taken with main clock stopped");

  AST_SLOW_CLOCK: assert property (@(posedge clock) disable iff (rst)
    accept && !clockOk |=> state_reg == FCS_ST_DONE)
    else $error("command started without slow clock and wait state");

  AST_RETRY_BOUND: assert property (@(posedge clock) disable iff (rst)
    state_reg == FCS_ST_RETRY |-> retry_reg < 2'(`FCS_ERASE_RETRIES) && op_reg == FCS_OP_ERASE)
    else $error("erase retried more than allowed");

  AST_RETRY_CLEARS: assert property (@(posedge clock) disable iff (rst)
    state_reg == FCS_ST_RETRY |=> memWe && memWdata[7:0] == `FCS_CODE_CLEAR_STATUS)
    else $error("erase retry without a clear status write");

  AST_PROGRAM_ORDER: assert property (@(posedge clock) disable iff (rst)
    state_reg == FCS_ST_BUS && op_reg == FCS_OP_PROGRAM && step_reg == 2'd1
    |=> memWe && memAddr == {addr_reg[AW-1:1], 1'b0} && memWdata == lo_reg)
    else $error("low program word not sent to the command address");

  AST_CONFIRM_CODE: assert property (@(posedge clock) disable iff (rst)
    state_reg == FCS_ST_BUS && needsPoll && op_reg != FCS_OP_PROGRAM && step_reg == 2'd1
    |=> memWe && memWdata == {`FCS_CODE_HIGH_BYTE, `FCS_CODE_CONFIRM})
    else $error("second cycle of a block command is not the confirm code");

  AST_POLL_ON_READY: assert property (@(posedge clock) disable iff (rst)
    state_reg == FCS_ST_POLL && state_next == FCS_ST_DONE && !flashRegsReset && !pollExpired
    |-> sequencerReadyFlag && $past(state_reg) == FCS_ST_POLL)
    else $error("operation finished before the ready flag returned");

  AST_NO_REPROGRAM: assert property (@(posedge clock) disable iff (rst)
    accept && cmdOp == FCS_OP_PROGRAM && lastProgValid_reg && lastProg_reg == cmdAddr
    |=> rspRefused)
    else $error("program of an already written word was taken");

endmodule

// [bench/fcs_flash_model.sv]
`timescale 1ns/100ps
module fcs_flash_model (
  input logic clock,
  input logic rst,
  input logic [19:0] memAddr,
  input logic [15:0] memWdata,
  input logic memWe,
  input logic memRe,
  output logic [15:0] memRdata,
  output logic memAck,
  input logic rewriteModeEnable,
  input logic lockFunctionDisable,
  input logic slow,
  input logic failErase,
  output logic sequencerReadyFlag,
  output logic programErrorFlag,
  output logic eraseErrorFlag,
  output logic lockStateResult
);
  // ----------------------------------------
  // device state and decode
  // ----------------------------------------
  logic [15:0] mem [1024];
  logic [1023:0] written;
  logic [7:0] first;
  logic loDone, statusMode;
  logic [3:0] locked, dirty;
  int busy, waitCnt;
  wire [1:0] blk = memAddr[13:12];
  wire [9:0] idx = {memAddr[13:12], memAddr[8:1]};
  wire [7:0] code = memWdata[7:0];
  wire errs = programErrorFlag | eraseErrorFlag;
  wire prot = locked[blk] & ~lockFunctionDisable;
  // slow mode holds the answer back three cycles to stretch the host's wait
  wire strobe = (memWe | memRe) & ~memAck & (waitCnt >= (slow ? 3 : 0));
  assign sequencerReadyFlag = (busy == 0);
  // one bus cycle per strobe; busy counts the auto operation down
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      memAck <= 1'b0;
      memRdata <= 16'h0000;
      written <= '0;
      {first, loDone, statusMode} <= 10'h000;
      {programErrorFlag, eraseErrorFlag, lockStateResult} <= 3'h1;
      {locked, dirty} <= 8'h00;
      busy <= 0;
      waitCnt <= 0;
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata; // a released bus never keeps the last word
      waitCnt <= ((memWe | memRe) & ~memAck) ? waitCnt + 1 : 0;
      if (busy > 0) busy <= busy - 1;
      if (!rewriteModeEnable) begin
        busy <= 0;
        first <= 8'h00;
      end
      if (strobe) memAck <= 1'b1;
      if (strobe && memRe) begin
        memRdata <= statusMode ? {8'h00, sequencerReadyFlag, 1'b0, eraseErrorFlag,
          programErrorFlag, 4'h0} : (written[idx] ? mem[idx] : 16'hFFFF);
      end else if (strobe && rewriteModeEnable) begin
        if (first == 8'h41) begin
          mem[idx] <= memWdata;
          written[idx] <= 1'b1;
          loDone <= ~loDone;
          if (loDone) begin
            first <= 8'h00;
            busy <= 20;
            statusMode <= 1'b1;
            if (prot) programErrorFlag <= 1'b1;
            else dirty[blk] <= 1'b1;
          end
        end else if (first != 8'h00) begin
          first <= 8'h00;
          if (code == 8'hFF) statusMode <= 1'b0;
          else if (code != 8'hD0) {programErrorFlag, eraseErrorFlag} <= 2'h3;
          else begin
            busy <= 20;
            statusMode <= 1'b1;
            case (first)
              8'h20: begin
                if (prot || failErase) eraseErrorFlag <= 1'b1;
                else {locked[blk], dirty[blk]} <= 2'h0;
              end
              8'h77: locked[blk] <= 1'b1;
              8'h71: lockStateResult <= ~locked[blk];
              default: eraseErrorFlag <= locked[blk] | dirty[blk];
            endcase
          end
        end else begin
          case (code)
            8'hFF: statusMode <= 1'b0;
            8'h70: statusMode <= 1'b1;
            8'h50: {programErrorFlag, eraseErrorFlag} <= 2'h0;
            8'h41, 8'h20, 8'h77, 8'h71, 8'h25: if (!errs) first <= code;
            default: {programErrorFlag, eraseErrorFlag} <= 2'h3;
          endcase
        end
      end
    end
  end
endmodule

// [bench/flash_command_sequencer_test.sv]
`timescale 1ns/100ps
module flash_command_sequencer_test
  import fcs_pkg::*;
;
  typedef struct {
    fcs_op_t op;
    logic [19:0] a;
    logic [15:0] lo, hi, d;
    logic [7:0] st;
    logic lk;
  } fcs_row_t;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clock, rst, cmdValid, rewriteRequest, lockDisableRequest, inPlaceRequest;
  logic mainClockStop, cpuClockSlow, waitStateSet, flashRegsReset, slow, failErase;
  fcs_op_t cmdOp;
  logic [19:0] cmdAddr, memAddr;
  logic [15:0] cmdDataLo, cmdDataHi, rspData, memWdata, memRdata;
  logic cmdReady, rspValid, rspRefused, rspTimeout, rspLock, memWe, memRe, memAck;
  logic [7:0] rspStatus;
  logic rewriteModeEnable, lockFunctionDisable, inPlaceRewriteMode;
  logic sequencerReadyFlag, programErrorFlag, eraseErrorFlag, lockStateResult;
  int failures = 0, comparisons = 0, writes = 0, eraseCodes = 0, n;
  // ordinary orders and the status, data and lock they should leave
  fcs_row_t rows [15] = '{
    '{FCS_OP_ERASE, 20'h00FFE, 16'h0, 16'h0, 16'h0, 8'h80, 1'b0},
    '{FCS_OP_BLANK_CHECK, 20'h00FFE, 16'h0, 16'h0, 16'h0, 8'h80, 1'b0},
    '{FCS_OP_PROGRAM, 20'h00100, 16'h1234, 16'h5678, 16'h0, 8'h80, 1'b0},
    '{FCS_OP_READ_ARRAY, 20'h00101, 16'h0, 16'h0, 16'h1234, 8'h80, 1'b0},
    '{FCS_OP_READ_ARRAY, 20'h00102, 16'h0, 16'h0, 16'h5678, 8'h80, 1'b0},
    '{FCS_OP_BLANK_CHECK, 20'h00FFE, 16'h0, 16'h0, 16'h0, 8'hA0, 1'b0},
    '{FCS_OP_CLEAR_STATUS, 20'h00000, 16'h0, 16'h0, 16'h0, 8'h80, 1'b0},
    '{FCS_OP_LOCK_PROGRAM, 20'h01FFE, 16'h0, 16'h0, 16'h0, 8'h80, 1'b0},
    '{FCS_OP_LOCK_READ, 20'h01FFE, 16'h0, 16'h0, 16'h0, 8'h80, 1'b0},
    '{FCS_OP_PROGRAM, 20'h01000, 16'hAAAA, 16'h5555, 16'h0, 8'h90, 1'b0},
    '{FCS_OP_READ_STATUS, 20'h00000, 16'h0, 16'h0, 16'h0090, 8'h90, 1'b0},
    '{FCS_OP_CLEAR_STATUS, 20'h00000, 16'h0, 16'h0, 16'h0, 8'h80, 1'b0},
    '{FCS_OP_BLANK_CHECK, 20'h01FFE, 16'h0, 16'h0, 16'h0, 8'hA0, 1'b0},
    '{FCS_OP_CLEAR_STATUS, 20'h00000, 16'h0, 16'h0, 16'h0, 8'h80, 1'b0},
    '{FCS_OP_LOCK_READ, 20'h00FFE, 16'h0, 16'h0, 16'h0, 8'h80, 1'b1}};
  // ----------------------------------------
  // design, device model, clock
  // ----------------------------------------
  fcs_host #(.AW(20), .POLL_LIMIT(64)) dut (.clock, .rst, .cmdValid, .cmdOp, .cmdAddr,
    .cmdDataLo, .cmdDataHi, .cmdReady, .rspValid, .rspRefused, .rspTimeout, .rspStatus,
    .rspData, .rspLock, .rewriteRequest, .lockDisableRequest, .inPlaceRequest,
    .mainClockStop, .cpuClockSlow, .waitStateSet, .flashRegsReset, .memAddr, .memWdata,
    .memWe, .memRe, .memRdata, .memAck, .rewriteModeEnable, .lockFunctionDisable,
    .inPlaceRewriteMode, .sequencerReadyFlag, .programErrorFlag, .eraseErrorFlag,
    .lockStateResult);
  fcs_flash_model flash (.clock, .rst, .memAddr, .memWdata, .memWe, .memRe, .memRdata,
    .memAck, .rewriteModeEnable, .lockFunctionDisable, .slow, .failErase,
    .sequencerReadyFlag, .programErrorFlag, .eraseErrorFlag, .lockStateResult);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ----------------------------------------
  // compare and order tasks
  // ----------------------------------------
  task automatic chk_bit(input string s, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", s, e, g);
    end
  endtask
  task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk16(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // holds the order until taken, then waits a bounded time for the answer pulse
  task automatic run_op(input fcs_op_t op, input logic [19:0] a, input logic [15:0] lo,
    input logic [15:0] hi);
    int k;
    k = 0;
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdAddr <= a;
    cmdDataLo <= lo;
    cmdDataHi <= hi;
    do @(posedge clock); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    do begin
      @(posedge clock);
      k++;
    end while (rspValid !== 1'b1 && k < 3000);
    chk_bit("rspValid", 1'b1, rspValid);
  endtask
  // a refused order must leave the device bus without a single write
  task automatic refuse(input string s, input fcs_op_t op, input logic [19:0] a);
    n = writes;
    run_op(op, a, 16'h0000, 16'h0000);
    chk_bit(s, 1'b1, rspRefused);
    chk16("busWrites", 16'(n), 16'(writes));
    $display("test %s done", s);
  endtask
  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // bus monitor: counts accepted writes, erase codes apart for the retry check
  always @(posedge clock) begin
    if (memWe && memAck) begin
      writes++;
      if (memWdata === 16'h0020) eraseCodes++;
      chk_bit("evenAddr", 1'b0, memAddr[0]);
    end
  end
  // under a thousand cycles expected; twenty thousand leaves wide room
  initial begin
    #1000000;
    failures++;
    $display("watchdog ran out");
    close_out;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rst, rewriteRequest, cpuClockSlow, waitStateSet} = 4'hF;
    {cmdValid, lockDisableRequest, inPlaceRequest, mainClockStop} = 4'h0;
    {flashRegsReset, slow, failErase} = 3'h0;
    cmdOp = FCS_OP_READ_ARRAY;
    cmdAddr = 20'h00000;
    {cmdDataLo, cmdDataHi} = 32'h0000_0000;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 15; i++) begin
      slow <= i[0];
      run_op(rows[i].op, rows[i].a, rows[i].lo, rows[i].hi);
      chk_bit("rspRefused", 1'b0, rspRefused);
      chk8("rspStatus", rows[i].st, rspStatus);
      if (rows[i].op inside {FCS_OP_READ_ARRAY, FCS_OP_READ_STATUS})
        chk16("rspData", rows[i].d, rspData);
      if (rows[i].op == FCS_OP_LOCK_READ)
        chk_bit("rspLock", rows[i].lk, rspLock);
      $display("test row %0d done", i);
    end
    slow <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    chk_bit("cmdReady", 1'b1, cmdReady);
    chk_bit("rspValid", 1'b0, rspValid);
    chk8("rspStatus", 8'h80, rspStatus);
    chk_bit("enable", 1'b0, rewriteModeEnable);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk_bit("enable", 1'b1, rewriteModeEnable);
    $display("test reset done");
    rewriteRequest <= 1'b0;
    repeat (3) @(posedge clock);
    refuse("disabled", FCS_OP_ERASE, 20'h00FFE);
    {rewriteRequest, mainClockStop} <= 2'h3;
    repeat (3) @(posedge clock);
    refuse("clockStopped", FCS_OP_ERASE, 20'h00FFE);
    {mainClockStop, cpuClockSlow} <= 2'h0;
    refuse("fastClock", FCS_OP_READ_ARRAY, 20'h00100);
    {cpuClockSlow, inPlaceRequest} <= 2'h3;
    repeat (2) @(posedge clock);
    chk_bit("inPlace", 1'b1, inPlaceRewriteMode);
    refuse("inPlaceStatus", FCS_OP_READ_STATUS, 20'h00000);
    inPlaceRequest <= 1'b0;
    run_op(FCS_OP_PROGRAM, 20'h00200, 16'h1111, 16'h2222);
    chk_bit("firstProgram", 1'b0, rspRefused);
    refuse("reprogram", FCS_OP_PROGRAM, 20'h00200);
    failErase <= 1'b1;
    n = eraseCodes;
    run_op(FCS_OP_ERASE, 20'h00FFE, 16'h0000, 16'h0000);
    chk8("retryStatus", 8'hA0, rspStatus);
    chk16("eraseTries", 16'(n + 4), 16'(eraseCodes));
    failErase <= 1'b0;
    run_op(FCS_OP_CLEAR_STATUS, 20'h00000, 16'h0000, 16'h0000);
    chk8("cleared", 8'h80, rspStatus);
    $display("test retry done");
    lockDisableRequest <= 1'b1;
    repeat (3) @(posedge clock);
    chk_bit("lockDisable", 1'b1, lockFunctionDisable);
    run_op(FCS_OP_LOCK_PROGRAM, 20'h01FFE, 16'h0000, 16'h0000);
    run_op(FCS_OP_ERASE, 20'h01FFE, 16'h0000, 16'h0000);
    chk8("lockedErase", 8'h80, rspStatus);
    run_op(FCS_OP_LOCK_READ, 20'h01FFE, 16'h0000, 16'h0000);
    chk_bit("unlocked", 1'b1, rspLock);
    lockDisableRequest <= 1'b0;
    $display("test lockDisable done");
    fork
      run_op(FCS_OP_ERASE, 20'h00FFE, 16'h0000, 16'h0000);
      begin
        repeat (14) @(posedge clock);
        flashRegsReset <= 1'b1;
        @(posedge clock);
        flashRegsReset <= 1'b0;
      end
    join
    chk_bit("rspTimeout", 1'b1, rspTimeout);
    chk_bit("enable", 1'b0, rewriteModeEnable);
    $display("test regsReset done");
    close_out;
  end
endmodule
